// ===== hw/uwt_pkg.sv
/*
  Shared constants for the upstream window translation block: register
  offsets, setup field positions, reset values and bus states.
  Assumes byte addressing on the register bus, one 32-bit word per register.
*/
package uwt_pkg;

  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_W0_BASE  = 8'he0;
  localparam logic [7:0] OFS_W0_SETUP = 8'he4;
  localparam logic [7:0] OFS_W1_BASE  = 8'he8;
  localparam logic [7:0] OFS_W1_SETUP = 8'hec;

  // Setup field positions
  localparam int unsigned TYPE_BIT = 0;
  localparam int unsigned AW_LSB   = 1;
  localparam int unsigned AW_MSB   = 2;
  localparam int unsigned PF_BIT   = 3;
  localparam int unsigned MASK_MSB = 30;
  localparam int unsigned EN_BIT   = 31;

  // Lowest translated bit of each window
  localparam int unsigned W0_LO = 12;
  localparam int unsigned W1_LO = 6;

  // Address width codes
  localparam logic [1:0] AW_32 = 2'h0;
  localparam logic [1:0] AW_64 = 2'h1;

  // Reset values
  localparam logic       TYPE_MEM = 1'h0;
  localparam logic       PF_RST   = 1'h0;
  localparam logic       W0_EN_RST = 1'h1;
  localparam logic       W1_EN_RST = 1'h0;

  // Base bits 31:12 returned on a window 0 sizing read
  localparam logic [19:0] W0_SIZING_READ = 20'hfffff;

  // Register bus states, one-hot
  typedef enum logic [1:0] {
    UWT_BUS_IDLE = 2'b01,
    UWT_BUS_ACK  = 2'b10
  } uwt_bus_state_t;

endpackage

// ===== hw/uwt_win_regs.sv
/*
  Setup and translated-base registers of one upstream window.
  Assumes setup loads come from the serial configuration path and base
  writes come already decoded from the register bus slave.
*/
`timescale 1ns/1ps
module uwt_win_regs #(
  parameter int unsigned LO      = 12,
  parameter logic        EN_RST  = 1'b1,
  parameter logic        EN_LOCK = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [31:0] load_data,
  input  wire logic        base_we,
  input  wire logic [31:0] base_wdata,
  input  wire logic [3:0]  base_be,
  output logic      [31:0] setup,
  output logic      [31:0] base
);

  logic [1:0]  aw;
  logic        pf;
  logic        en;
  logic [30:LO] mask;
  logic [31:LO] base_q;
  logic [1:0]  next_aw;
  logic        next_pf;
  logic        next_en;
  logic [30:LO] next_mask;
  logic [31:LO] next_base;
  logic [31:0] be_bits;

  if (LO < 1 || LO > 30) begin : g_chk
    $error("uwt_win_regs: LO out of range");
  end

  always_comb begin
    next_aw   = aw;
    next_pf   = pf;
    next_en   = en;
    next_mask = mask;
    next_base = base_q;
    be_bits   = {{8{base_be[3]}}, {8{base_be[2]}}, {8{base_be[1]}}, {8{base_be[0]}}};
    // Setup fields change only through the load path
    if (load) begin
      next_aw   = load_data[uwt_pkg::AW_MSB:uwt_pkg::AW_LSB];
      next_pf   = load_data[uwt_pkg::PF_BIT];
      next_mask = load_data[uwt_pkg::MASK_MSB:LO];
      next_en   = EN_LOCK ? 1'b1 : load_data[uwt_pkg::EN_BIT];
    end
    // Bit 31 writable under its byte enable, lower bits only where the size mask is set
    if (base_we) begin
      for (int i = LO; i <= 31; i++) begin
        if (be_bits[i] && (i == 31 || mask[i])) begin
          next_base[i] = base_wdata[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw     <= uwt_pkg::AW_32;
      pf     <= uwt_pkg::PF_RST;
      en     <= EN_RST;
      mask   <= '0;
      base_q <= '0;
    end else if (ce) begin
      aw     <= next_aw;
      pf     <= next_pf;
      en     <= next_en;
      mask   <= next_mask;
      base_q <= next_base;
    end
  end

  always_comb begin
    setup = '0;
    setup[uwt_pkg::TYPE_BIT]                 = uwt_pkg::TYPE_MEM;
    setup[uwt_pkg::AW_MSB:uwt_pkg::AW_LSB]   = aw;
    setup[uwt_pkg::PF_BIT]                   = pf;
    setup[uwt_pkg::MASK_MSB:LO]              = mask;
    setup[uwt_pkg::EN_BIT]                   = en;
    base        = '0;
    base[31:LO] = base_q;
  end

endmodule

// ===== hw/uwt_xlate.sv
/*
  Combinational address translation for one upstream window.
  Assumes setup and base words laid out as held by uwt_win_regs.
*/
`timescale 1ns/1ps
module uwt_xlate #(
  parameter int unsigned LO = 12
) (
  input  wire logic [31:0] setup,
  input  wire logic [31:0] base,
  input  wire logic [31:0] addr,
  output logic             hit,
  output logic      [31:0] out_addr
);

  logic [31:0] sel;

  if (LO < 1 || LO > 30) begin : g_chk
    $error("uwt_xlate: LO out of range");
  end

  always_comb begin
    sel = '0;
    sel[31] = 1'b1;
    sel[uwt_pkg::MASK_MSB:LO] = setup[uwt_pkg::MASK_MSB:LO];
    hit = setup[uwt_pkg::EN_BIT];
    // Masked bits come from the base, offset bits pass through
    if (hit) begin
      out_addr = (base & sel) | (addr & ~sel);
    end else begin
      out_addr = addr;
    end
  end

endmodule

// ===== hw/uwt_top.sv
/*
  Upstream window translation block: two windows with setup and
  translated-base registers behind an Avalon-MM slave, a setup load
  port and a registered upstream address translator.
  Assumes one clock, synchronous active-low reset, and that the bus
  master holds its request until waitrequest is seen low.
*/
// Summary of operation
// - Window 0 base bit 31 and mask-selected bits 30:12 replace address
// - Window 1 base bit 31 and mask-selected bits 30:6 replace address
// - Setup bit 0 always reads zero
// - Setup width code and prefetch bit, reset zero
// - Mask bit one makes base bit writable
// - Window 0 enable resets one, stays one
// - Window 0 sizing read returns FFFFFh
// - Window 1 enable switches window, resets zero
`timescale 1ns/1ps
module uwt_top #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              setup_load_valid,
  input  wire logic              setup_load_window,
  input  wire logic [31:0]       setup_load_data,
  input  wire logic              up_req,
  input  wire logic              up_window,
  input  wire logic [31:0]       up_addr,
  output logic                   xlate_valid,
  output logic                   xlate_hit,
  output logic                   xlate_window,
  output logic      [31:0]       xlate_addr
);

  uwt_pkg::uwt_bus_state_t state;
  uwt_pkg::uwt_bus_state_t next_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        sizing;
  logic        next_sizing;
  logic        v_q;
  logic        hit_q;
  logic        win_q;
  logic [31:0] addr_q;
  logic        next_v;
  logic        next_hit;
  logic        next_win;
  logic [31:0] next_addr;

  logic        req;
  logic        take;
  logic        do_write;
  logic        do_read;
  logic        sel_b0;
  logic        sel_s0;
  logic        sel_b1;
  logic        sel_s1;
  logic        mapped;
  logic        load0;
  logic        load1;
  logic        b0_we;
  logic        b1_we;
  logic        b0_all_ones;
  logic [31:0] setup0;
  logic [31:0] setup1;
  logic [31:0] base0;
  logic [31:0] base1;
  logic        hit0;
  logic        hit1;
  logic [31:0] xa0;
  logic [31:0] xa1;
  logic [31:0] rd_mux;

  if (ADDR_W < 8) begin : g_chk
    $error("uwt_top: ADDR_W must be at least 8");
  end

  // Address decode, upper bits must be zero for a hit
  always_comb begin
    sel_b0 = (avs_address == ADDR_W'(uwt_pkg::OFS_W0_BASE));
    sel_s0 = (avs_address == ADDR_W'(uwt_pkg::OFS_W0_SETUP));
    sel_b1 = (avs_address == ADDR_W'(uwt_pkg::OFS_W1_BASE));
    sel_s1 = (avs_address == ADDR_W'(uwt_pkg::OFS_W1_SETUP));
    mapped = sel_b0 | sel_s0 | sel_b1 | sel_s1;
  end

  // One wait cycle per access; the request completes in the ACK cycle
  // Clock enable low holds the answer back so no access is lost
  always_comb begin
    req             = avs_read | avs_write;
    take            = (state == uwt_pkg::UWT_BUS_ACK) && req && ce;
    do_write        = take && avs_write;
    do_read         = take && avs_read;
    avs_waitrequest = req && !take;
    avs_readdata    = rdata;
  end

  always_comb begin
    next_state = state;
    unique case (state)
      uwt_pkg::UWT_BUS_IDLE: begin
        if (req && ce) begin
          next_state = uwt_pkg::UWT_BUS_ACK;
        end
      end
      uwt_pkg::UWT_BUS_ACK: begin
        next_state = uwt_pkg::UWT_BUS_IDLE;
      end
      default: begin
        next_state = uwt_pkg::UWT_BUS_IDLE;
      end
    endcase
  end

  // Setup registers ignore bus writes; only base registers take them
  always_comb begin
    b0_we = do_write && sel_b0;
    b1_we = do_write && sel_b1;
    load0 = setup_load_valid && !setup_load_window;
    load1 = setup_load_valid && setup_load_window;
    b0_all_ones = (avs_writedata[31:uwt_pkg::W0_LO] == '1) &&
                  (avs_byteenable[3:1] == 3'h7);
  end

  // Sizing: all ones written to window 0 base arms the next window 0 base read
  always_comb begin
    next_sizing = sizing;
    if (b0_we) begin
      next_sizing = b0_all_ones;
    end else if (do_write) begin
      next_sizing = 1'b0;
    end else if (do_read && sel_b0) begin
      next_sizing = 1'b0;
    end
  end

  // Read data captured while waitrequest is high, shown in the ACK cycle
  always_comb begin
    rd_mux = '0;
    if (sel_b0) begin
      rd_mux = base0;
      if (sizing) begin
        rd_mux[31:uwt_pkg::W0_LO] = uwt_pkg::W0_SIZING_READ;
      end
    end else if (sel_s0) begin
      rd_mux = setup0;
    end else if (sel_b1) begin
      rd_mux = base1;
    end else if (sel_s1) begin
      rd_mux = setup1;
    end
    next_rdata = rdata;
    if ((state == uwt_pkg::UWT_BUS_IDLE) && avs_read) begin
      next_rdata = mapped ? rd_mux : '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state  <= uwt_pkg::UWT_BUS_IDLE;
      rdata  <= '0;
      sizing <= 1'b0;
    end else if (ce) begin
      state  <= next_state;
      rdata  <= next_rdata;
      sizing <= next_sizing;
    end
  end

  uwt_win_regs #(
    .LO      (uwt_pkg::W0_LO),
    .EN_RST  (uwt_pkg::W0_EN_RST),
    .EN_LOCK (1'b1)
  ) u_win0 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .load       (load0),
    .load_data  (setup_load_data),
    .base_we    (b0_we),
    .base_wdata (avs_writedata),
    .base_be    (avs_byteenable),
    .setup      (setup0),
    .base       (base0)
  );

  // Window 1 mask bits 11:6 are left to the loader in memory mode
  uwt_win_regs #(
    .LO      (uwt_pkg::W1_LO),
    .EN_RST  (uwt_pkg::W1_EN_RST),
    .EN_LOCK (1'b0)
  ) u_win1 (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .load       (load1),
    .load_data  (setup_load_data),
    .base_we    (b1_we),
    .base_wdata (avs_writedata),
    .base_be    (avs_byteenable),
    .setup      (setup1),
    .base       (base1)
  );

  uwt_xlate #(
    .LO (uwt_pkg::W0_LO)
  ) u_xlate0 (
    .setup    (setup0),
    .base     (base0),
    .addr     (up_addr),
    .hit      (hit0),
    .out_addr (xa0)
  );

  uwt_xlate #(
    .LO (uwt_pkg::W1_LO)
  ) u_xlate1 (
    .setup    (setup1),
    .base     (base1),
    .addr     (up_addr),
    .hit      (hit1),
    .out_addr (xa1)
  );

  // Registered translation result, one cycle after the request
  always_comb begin
    next_v    = up_req;
    next_win  = v_q ? win_q : 1'b0;
    next_hit  = 1'b0;
    next_addr = addr_q;
    if (up_req) begin
      next_win  = up_window;
      next_hit  = up_window ? hit1 : hit0;
      next_addr = up_window ? xa1 : xa0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      v_q    <= 1'b0;
      hit_q  <= 1'b0;
      win_q  <= 1'b0;
      addr_q <= '0;
    end else if (ce) begin
      v_q    <= next_v;
      hit_q  <= next_hit;
      win_q  <= next_win;
      addr_q <= next_addr;
    end
  end

  always_comb begin
    xlate_valid  = v_q;
    xlate_hit    = hit_q;
    xlate_window = win_q;
    xlate_addr   = addr_q;
  end

endmodule

// ===== tb/uwt_top_chk.sv
/* Port checker for uwt_top.
   Assumes it is bound to uwt_top and sees only its ports. */
`timescale 1ns/1ps
module uwt_top_chk #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              up_req,
  input wire logic              up_window,
  input wire logic [31:0]       up_addr,
  input wire logic              xlate_valid,
  input wire logic              xlate_hit,
  input wire logic              xlate_window,
  input wire logic [31:0]       xlate_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_req_wait;
    ce && (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd(logic [ADDR_W-1:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  AST_WAIT_ONE: assert property (s_req_wait |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  AST_W0_RSV: assert property (s_rd(8'he0) |-> avs_readdata[11:0] == 12'h000)
    else $error("window 0 base low bits not zero");
  AST_W1_RSV: assert property (s_rd(8'he8) |-> avs_readdata[5:0] == 6'h00)
    else $error("window 1 base low bits not zero");
  AST_TYPE: assert property ((s_rd(8'he4) or s_rd(8'hec)) |-> !avs_readdata[0])
    else $error("setup type bit not zero");
  AST_W0_EN: assert property (s_rd(8'he4) |-> avs_readdata[31])
    else $error("window 0 enable not one");
  AST_XVALID: assert property (ce |=> xlate_valid == $past(up_req))
    else $error("translate valid not one cycle after request");
  AST_XWIN: assert property (ce && up_req |=> xlate_window == $past(up_window))
    else $error("translate window mismatch");
  AST_OFS0: assert property (ce && up_req && !up_window |=>
    xlate_hit && ((xlate_addr ^ $past(up_addr)) & 32'h00000fff) == 32'h0)
    else $error("window 0 offset or hit wrong");
  AST_OFS1: assert property (ce && up_req && up_window |=>
    ((xlate_addr ^ $past(up_addr)) & 32'h0000003f) == 32'h0)
    else $error("window 1 offset wrong");
  AST_MISS: assert property (ce && up_req |=> xlate_hit || xlate_addr == $past(up_addr))
    else $error("disabled window altered address");
endmodule

// ===== tb/uwt_up_agent.sv
/* Upstream master and setup loader model facing uwt_top.
   Assumes the bench strobes go inputs one cycle ahead. */
`timescale 1ns/1ps
module uwt_up_agent (
  input wire logic        sys_clk,
  input wire logic        xl_go,
  input wire logic        xl_win,
  input wire logic [31:0] xl_addr,
  input wire logic        ld_go,
  input wire logic        ld_win,
  input wire logic [31:0] ld_data,
  output logic            up_req,
  output logic            up_window,
  output logic     [31:0] up_addr,
  output logic            setup_load_valid,
  output logic            setup_load_window,
  output logic     [31:0] setup_load_data
);
  initial begin
    up_req = 1'b0;
    up_window = 1'b0;
    up_addr = 32'h0;
    setup_load_valid = 1'b0;
    setup_load_window = 1'b0;
    setup_load_data = 32'h0;
  end
  // Idle lines flip so stale values never pass
  always @(posedge sys_clk) begin
    up_req <= xl_go;
    up_window <= xl_go ? xl_win : ~up_window;
    up_addr <= xl_go ? xl_addr : ~up_addr;
    setup_load_valid <= ld_go;
    setup_load_window <= ld_go ? ld_win : ~setup_load_window;
    setup_load_data <= !ld_go ? ~setup_load_data :
                       ld_win ? (ld_data & 32'hfffff03f) : ld_data;
  end
endmodule

// ===== tb/uwt_top_tb.sv
/* Self-checking bench for uwt_top.
   Assumes one 250 MHz clock and ce held high except in t_freeze. */
`timescale 1ns/1ps
module uwt_top_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        xl_go = 1'b0, xl_win = 1'b0, ld_go = 1'b0, ld_win = 1'b0;
  logic [31:0] xl_addr = 32'h0, ld_data = 32'h0;
  logic [31:0] avs_readdata, up_addr, setup_load_data, xlate_addr;
  logic        avs_waitrequest, up_req, up_window, setup_load_valid;
  logic        setup_load_window, xlate_valid, xlate_hit, xlate_window;
  int          fails = 0;
  int          check_count = 0;
  always #2 sys_clk = ~sys_clk;
  uwt_top #(.ADDR_W(8)) uwt_top_i (.sys_clk, .rst_n, .ce, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .setup_load_valid, .setup_load_window, .setup_load_data, .up_req, .up_window,
    .up_addr, .xlate_valid, .xlate_hit, .xlate_window, .xlate_addr);
  uwt_up_agent uwt_up_agent_i (.sys_clk, .xl_go, .xl_win, .xl_addr, .ld_go, .ld_win,
    .ld_data, .up_req, .up_window, .up_addr, .setup_load_valid, .setup_load_window,
    .setup_load_data);
  task automatic wrap_up;
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      fails++;
      $display("[FAIL] %0t bus timeout", $time);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask
  task automatic ld(input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    ld_go <= 1'b1;
    ld_win <= w;
    ld_data <= d;
    @(posedge sys_clk);
    ld_go <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic xl(input logic w, input logic [31:0] a, input logic h,
                    input logic [31:0] e);
    @(posedge sys_clk);
    xl_go <= 1'b1;
    xl_win <= w;
    xl_addr <= a;
    @(posedge sys_clk);
    xl_go <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({29'h0, xlate_valid, xlate_hit, xlate_window}, {29'h0, 1'b1, h, w});
    chk(xlate_addr, e);
  endtask
  task automatic t_reset;
    rd(8'he0, 32'h0);
    rd(8'he4, 32'h80000000);
    rd(8'he8, 32'h0);
    rd(8'hec, 32'h0);
    rd(8'h10, 32'h0);
  endtask
  task automatic t_setup_ro;
    wr(8'he4, 32'h0, 4'hf);
    wr(8'hec, 32'hffffffff, 4'hf);
    wr(8'h10, 32'hffffffff, 4'hf);
    rd(8'he4, 32'h80000000);
    rd(8'hec, 32'h0);
  endtask
  task automatic t_load;
    xl(1'b1, 32'h12345678, 1'b0, 32'h12345678);
    ld(1'b0, 32'h0000f00b);
    ld(1'b1, 32'h8000ffc2);
    rd(8'he4, 32'h8000f00a);
    rd(8'hec, 32'h8000f002);
  endtask
  task automatic t_base;
    wr(8'he0, 32'hffffffff, 4'hf);
    rd(8'he0, 32'hfffff000);
    rd(8'he0, 32'h8000f000);
    wr(8'he8, 32'hffffffff, 4'hf);
    rd(8'he8, 32'h8000f000);
    wr(8'he8, 32'h0, 4'h1);
    rd(8'he8, 32'h8000f000);
  endtask
  task automatic t_xlate;
    xl(1'b0, 32'h12345678, 1'b1, 32'h9234f678);
    xl(1'b1, 32'h00000abc, 1'b1, 32'h8000fabc);
    ld(1'b1, 32'h0000ffc2);
    xl(1'b1, 32'h00000abc, 1'b0, 32'h00000abc);
  endtask
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    ld(1'b0, 32'h00000000);
    @(posedge sys_clk);
    xl_go <= 1'b1;
    xl_win <= 1'b0;
    xl_addr <= 32'h00000001;
    @(posedge sys_clk);
    xl_go <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({31'h0, xlate_valid}, 32'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(8'he4, 32'h8000f00a);
  endtask
  task automatic t_rerun;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_setup_ro();
    t_load();
    t_base();
    t_xlate();
    t_freeze();
    t_rerun();
    wrap_up();
  end
endmodule
bind uwt_top uwt_top_chk #(.ADDR_W(ADDR_W)) uwt_top_chk_i (.sys_clk, .rst_n, .ce,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .up_req,
  .up_window, .up_addr, .xlate_valid, .xlate_hit, .xlate_window, .xlate_addr);
